// ===== core/flash_block_protection.sv
// Purpose: flash array with 1 KB block erase and 2 KB region read-only / execute-only guards
// Assumes: one request per cycle on a valid/ready handshake; protection masks are static levels
// Notes: erase walks the block one word per cycle; requests stall while it runs
//
// Functional notes
// - array holds 64 KB, reached through this controller only.
// - erase clears one 1 KB block, independent of all others.
// - after erase every bit of that block reads as one.
// - protection applies per 2 KB region of two adjacent blocks.
// - each region may be marked read-only or execute-only.
// - read-only regions refuse erase and program.
// - execute-only regions refuse erase and program.
// - execute-only regions serve only instruction fetch reads; data and debug denied.
`timescale 1ns/1ps
`default_nettype none
module flash_block_protection
	import flash_prot_pkg::*;
#(
	parameter int FLASH_SIZE  = FLASH_BYTES,
	parameter int BLOCK_SIZE  = BLOCK_BYTES,
	parameter int REGION_SIZE = BLOCK_BYTES + BLOCK_BYTES
)
(
	// clock and reset
	input  wire logic                                  core_clk,
	input  wire logic                                  reset,
	// protection markings, one bit per 2 KB region
	input  wire logic [flash_prot_pkg::REGION_COUNT-1:0] readOnly,
	input  wire logic [flash_prot_pkg::REGION_COUNT-1:0] execOnly,
	// request
	input  wire logic                                  reqValid,
	output      logic                                  reqReady,
	input  wire flash_prot_pkg::flash_req_s            req,
	// response
	output      logic                                  rspValid,
	output var  flash_prot_pkg::flash_rsp_s            rsp
);
	import flash_prot_pkg::*;

	// the address decode below serves only this fixed array geometry
	if (FLASH_SIZE != FLASH_BYTES)
	begin
		$error("flash size parameter must equal the 64 KB array");
	end
	if (BLOCK_SIZE != BLOCK_BYTES)
	begin
		$error("erase block parameter must equal the 1 KB block");
	end
	if (REGION_SIZE != BLOCK_SIZE + BLOCK_SIZE)
	begin
		$error("a protection region must span two erase blocks");
	end
	if (FLASH_SIZE / REGION_SIZE != REGION_COUNT)
	begin
		$error("one mark bit is needed per protection region");
	end
	if (FLASH_SIZE != (1 << ADDR_W))
	begin
		$error("byte address width must cover the array exactly");
	end
	if (BLOCK_SIZE != BLOCK_WORDS * (WORD_W / 8))
	begin
		$error("erase walk length must cover one block");
	end

	typedef enum {ST_IDLE, ST_ERASE} state_e;
	typedef logic [WORD_ADDR_W-WORD_IN_BLOCK_W-1:0] block_t;

	// protection region of a byte address: the bits above the 2 KB boundary
	function automatic logic [REGION_W-1:0] regionOf(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:REGION_SHIFT];
	endfunction

	// erase block of a byte address: the bits above the 1 KB boundary
	function automatic block_t blockOf(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:BLOCK_SHIFT];
	endfunction

	// contents are not reset; a word is unknown until programmed or erased
	logic [WORD_W-1:0] mem [0:(FLASH_SIZE/4)-1];

	state_e                     state;
	logic [WORD_ADDR_W-1:WORD_IN_BLOCK_W] eraseBlock;
	logic [WORD_IN_BLOCK_W-1:0] eraseIdx;
	state_e                     next_state;
	block_t                     next_eraseBlock;
	logic [WORD_IN_BLOCK_W-1:0] next_eraseIdx;
	logic                       next_rspValid;
	logic                       next_denied;

	wire logic                   take      = reqValid && reqReady;
	wire logic [REGION_W-1:0]    reqRegion = regionOf(req.addr);
	wire logic                   isRo      = readOnly[reqRegion];
	wire logic                   isXo      = execOnly[reqRegion];
	wire logic                   isModify  = (req.op == OP_PROGRAM) || (req.op == OP_ERASE);
	wire logic                   denyMod   = isModify && (isRo || isXo);
	wire logic                   denyRead  = (req.op == OP_READ) && isXo
	                                          && (req.src != SRC_FETCH);
	wire logic                   denied    = denyMod || denyRead;
	wire logic [WORD_ADDR_W-1:0] wordAddr  = req.addr[ADDR_W-1:2];
	wire logic [WORD_ADDR_W-1:0] eraseAddr = {eraseBlock, eraseIdx};
	wire logic                   lastWord  = (eraseIdx == WORD_IN_BLOCK_W'(BLOCK_WORDS-1));

	// actions of the request taken at this edge; refusals never reach the array
	wire logic                   allowed    = take && !denied;
	wire block_t                 reqBlock   = blockOf(req.addr);
	wire logic                   eraseGo    = allowed && (req.op == OP_ERASE);
	wire logic                   progGo     = allowed && (req.op == OP_PROGRAM);
	wire logic                   readGo     = allowed && (req.op == OP_READ);
	wire logic                   eraseWrite = (state == ST_ERASE);

	// one array write port shared by the erase walk and programming
	wire logic                   writeEn    = !reset && (eraseWrite || progGo);
	wire logic [WORD_ADDR_W-1:0] writeAddr  = eraseWrite ? eraseAddr : wordAddr;
	wire logic [WORD_W-1:0]      writeData  = eraseWrite ? ERASED_WORD : req.wdata;
	wire logic [WORD_W-1:0]      next_rdata = readGo ? mem[wordAddr] : '0;

	assign reqReady = (state == ST_IDLE);

	// control: an allowed erase walks its block one word per cycle, then idles
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
			begin
				if (eraseGo)
					next_state = ST_ERASE;
			end
			ST_ERASE:
			begin
				if (lastWord)
					next_state = ST_IDLE;
			end
			default:
			begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// erase walk position: block latched at the start, word counted up from zero
	always_comb
	begin
		next_eraseBlock = eraseBlock;
		next_eraseIdx   = eraseIdx;
		case (state)
			ST_IDLE:
			begin
				if (eraseGo)
				begin
					next_eraseBlock = reqBlock;
					next_eraseIdx   = '0;
				end
			end
			ST_ERASE:
			begin
				next_eraseIdx = eraseIdx + 1'b1;
			end
			default:
			begin
				next_eraseIdx = '0;
			end
		endcase
	end

	// answer at once for every taken request but an allowed erase, which answers
	// once the last word of its block is written; denied answers carry no data
	always_comb
	begin
		next_rspValid = 1'b0;
		next_denied   = 1'b0;
		case (state)
			ST_IDLE:
			begin
				next_rspValid = take && (denied || (req.op != OP_ERASE));
				next_denied   = take && denied;
			end
			ST_ERASE:
			begin
				next_rspValid = lastWord;
			end
			default:
			begin
				next_rspValid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state      <= ST_IDLE;
			eraseBlock <= '0;
			eraseIdx   <= '0;
		end
		else
		begin
			state      <= next_state;
			eraseBlock <= next_eraseBlock;
			eraseIdx   <= next_eraseIdx;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (writeEn)
			mem[writeAddr] <= writeData;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			rspValid <= 1'b0;
			rsp      <= '0;
		end
		else
		begin
			rspValid   <= next_rspValid;
			rsp.denied <= next_denied;
			rsp.rdata  <= next_rdata;
		end
	end
endmodule
`default_nettype wire

// ===== core/flash_prot_pkg.sv
// Purpose: shared constants and carrier types for the flash block protection logic
// Assumes: 64 KB array, 32-bit words, 1 KB erase blocks, 2 KB protection regions
// Notes: byte addresses throughout; word index is address bits above the byte lane
package flash_prot_pkg;
	localparam int FLASH_BYTES      = 65536;
	localparam int ADDR_W           = 16;
	localparam int WORD_W           = 32;
	localparam int WORD_ADDR_W      = 14;
	localparam int BLOCK_BYTES      = 1024;
	localparam int BLOCK_SHIFT      = 10;
	localparam int BLOCK_WORDS      = 256;
	localparam int WORD_IN_BLOCK_W  = 8;
	localparam int REGION_SHIFT     = 11;
	localparam int REGION_COUNT     = 32;
	localparam int REGION_W         = 5;
	localparam logic [WORD_W-1:0]       ERASED_WORD  = 32'hFFFFFFFF;
	localparam logic [REGION_COUNT-1:0] PROT_RESET   = 32'h00000000;

	typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_ERASE} flash_op_e;
	typedef enum logic [1:0] {SRC_FETCH, SRC_DATA, SRC_DEBUG} flash_src_e;

	typedef struct packed {
		flash_op_e              op;
		flash_src_e             src;
		logic [ADDR_W-1:0]      addr;
		logic [WORD_W-1:0]      wdata;
	} flash_req_s;

	typedef struct packed {
		logic                   denied;
		logic [WORD_W-1:0]      rdata;
	} flash_rsp_s;
endpackage

// ===== test/flash_block_protection_sva.sv
// Purpose: port checks. Assumes: erase answers 257 cycles after take. Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module flash_block_protection_sva
	import flash_prot_pkg::*;
(
	// top ports
	input wire logic	core_clk,
	input wire logic	reset,
	input wire logic [31:0]	readOnly,
	input wire logic [31:0]	execOnly,
	input wire logic	reqValid,
	input wire logic	reqReady,
	input wire flash_prot_pkg::flash_req_s	req,
	input wire logic	rspValid,
	input wire flash_prot_pkg::flash_rsp_s	rsp
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	wire	tk = reqValid && reqReady;
	wire	xo = execOnly[req.addr[15:11]];
	wire	pr = xo | readOnly[req.addr[15:11]];
	wire	rd = tk && req.op == OP_READ;
	wire	dr = rd && req.src != SRC_FETCH;
	wire	we = tk && req.op == OP_ERASE;
	wire	ok = rspValid && !rsp.denied;
	sequence erasing; !reqReady [*8] ##249 rspValid && reqReady; endsequence
	a_wr_guard: assert property (tk && !rd && pr |=> rspValid && rsp.denied) else $error("g");
	a_prog_open: assert property (tk && !rd && !we && !pr |=> ok) else $error("p");
	a_erase_run: assert property (we && !pr |=> erasing) else $error("e");
	a_xo_read: assert property (dr && xo |=> rspValid && rsp.denied) else $error("x");
	a_fetch_ok: assert property (rd && !dr |=> ok) else $error("f");
	a_ro_read: assert property (rd && !xo |=> ok) else $error("r");
	a_busy_quiet: assert property (!reqReady |=> !rspValid || reqReady) else $error("b");
	a_denied_blank: assert property (rspValid && rsp.denied |-> rsp.rdata == '0) else $error("d");
endmodule
bind flash_block_protection flash_block_protection_sva flash_block_protection_sva_inst (
	.core_clk(core_clk), .reset(reset), .readOnly(readOnly), .execOnly(execOnly),
	.reqValid(reqValid), .reqReady(reqReady), .req(req), .rspValid(rspValid), .rsp(rsp));
`default_nettype wire

// ===== test/flash_requester.sv
// Purpose: requester model. Assumes: one request at a time. Notes: idle lines show inverse
`timescale 1ns/1ps
`default_nettype none
module flash_requester
	import flash_prot_pkg::*;
(
	// handshake and answer
	input wire logic	core_clk,
	input wire logic	reqReady,
	input wire logic	rspValid,
	input wire flash_prot_pkg::flash_rsp_s	rsp,
	output logic	reqValid,
	output var flash_prot_pkg::flash_req_s	req
);
	initial {reqValid, req} = '0;
	task automatic send(flash_req_s q, output flash_rsp_s r);
		int n = 0;
		reqValid <= 1'h1;
		req <= q;
		do @(negedge core_clk); while (!reqReady);
		@(posedge core_clk);
		reqValid <= 1'h0;
		req <= ~q;
		do @(negedge core_clk); while (!rspValid && ++n < 300);
		r = rspValid ? rsp : 'x; // a missing answer never matches
		@(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// Purpose: bench. Assumes: marks are levels. Notes: region 0 read-only, region 1 exec-only
`timescale 1ns/1ps
`default_nettype none
module tb;
	import flash_prot_pkg::*;
	localparam logic [32:0]	NO = 33'h100000000;
	logic	core_clk = 0;
	logic	reset = 1;
	logic [31:0]	readOnly = '0;
	logic [31:0]	execOnly = '0;
	logic	reqValid, reqReady, rspValid;
	flash_req_s	req;
	flash_rsp_s	rsp;
	int	failures = 0;
	int	n_compared = 0;
	int	cyc = 0;
	always #20 core_clk = ~core_clk;
	flash_block_protection flash_block_protection_inst (.core_clk(core_clk), .reset(reset),
		.readOnly(readOnly), .execOnly(execOnly), .reqValid(reqValid), .reqReady(reqReady),
		.req(req), .rspValid(rspValid), .rsp(rsp));
	flash_requester flash_requester_inst (.core_clk(core_clk), .reqReady(reqReady),
		.rspValid(rspValid), .rsp(rsp), .reqValid(reqValid), .req(req));
	task automatic x(flash_op_e o, flash_src_e s, logic [15:0] a, logic [31:0] d, logic [32:0] e);
		flash_rsp_s r;
		flash_requester_inst.send({o, s, a, d}, r);
		n_compared++;
		if (r !== e)
		begin
			failures++;
			$display("MISMATCH rsp exp %h got %h", e, r);
		end
	endtask
	task t_erase;
		x(OP_PROGRAM, SRC_DATA, 16'h13FC, '0, '0);
		x(OP_PROGRAM, SRC_DEBUG, 16'h1400, 32'hA5A5F00F, '0);
		x(OP_ERASE, SRC_DATA, 16'h1000, '0, '0);
		x(OP_READ, SRC_DEBUG, 16'h13FC, '0, 33'h0FFFFFFFF);
		x(OP_READ, SRC_DATA, 16'h1000, '0, 33'h0FFFFFFFF);
		x(OP_READ, SRC_FETCH, 16'h1400, '0, 33'h0A5A5F00F);
	endtask
	task t_marks;
		x(OP_PROGRAM, SRC_DATA, 16'h0800, 32'h1234ABCD, '0);
		x(OP_PROGRAM, SRC_DATA, 16'h07FC, 32'hC3C3C3C3, '0);
		readOnly <= 32'h1;
		execOnly <= 32'h2;
		x(OP_PROGRAM, SRC_DATA, 16'h07FC, '0, NO);
		x(OP_ERASE, SRC_DATA, 16'h0400, '0, NO);
		x(OP_ERASE, SRC_DATA, 16'h0800, '0, NO);
		x(OP_READ, SRC_DATA, 16'h0800, '0, NO);
		x(OP_READ, SRC_DEBUG, 16'h0A00, '0, NO);
		x(OP_READ, SRC_DATA, 16'h07FC, '0, 33'h0C3C3C3C3);
		x(OP_READ, SRC_FETCH, 16'h0800, '0, 33'h01234ABCD);
		x(OP_PROGRAM, SRC_DATA, 16'h1000, 32'h5, '0);
		x(OP_READ, SRC_DEBUG, 16'h1000, '0, 33'h000000005);
	endtask
	task results;
		if (failures == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk)
		if (++cyc == 2000)
		begin
			failures++;
			results;
		end
	initial
	begin
		repeat (2) @(posedge core_clk);
		reset <= 1'h0;
		t_erase;
		t_marks;
		results;
	end
endmodule
`default_nettype wire
